/* File: inc/csmcc_map.vh */
`ifndef CSMCC_MAP_VH
`define CSMCC_MAP_VH

// Register byte offsets on the APB slave.
`define CSMCC_OFS_STATUS 8'h00
`define CSMCC_OFS_MODE 8'h04
`define CSMCC_OFS_COMM 8'h08
`define CSMCC_OFS_MASK 8'h0C
`define CSMCC_OFS_START 8'h10
`define CSMCC_OFS_STOP 8'h14
`define CSMCC_OFS_DATA 8'h18
`define CSMCC_OFS_COUNT 8'h1C
`define CSMCC_OFS_ENABLED 8'h20

// Field positions.
`define CSMCC_ST_ACTIVE 6
`define CSMCC_ST_BUF_FULL 5
`define CSMCC_ST_OVERRUN 0
`define CSMCC_MODE_IRQ_SRC 0
`define CSMCC_MODE_FIXED_ONE 5
`define CSMCC_COMM_TX_EN 15
`define CSMCC_COMM_RX_EN 14
`define CSMCC_MASK_SERIAL 3
`define CSMCC_TRIG_CH 0

// Reset values.
`define CSMCC_RST_MODE 16'h0020
`define CSMCC_RST_COMM 16'h0007
`define CSMCC_RST_MASK 8'hFF
`define CSMCC_RST_COUNT 8'h01

// Timing: system clock and serial link clock periods in ns.
`define CSMCC_CLK_PERIOD_NS 100
`define CSMCC_LINK_PERIOD_NS 800
`define CSMCC_HALF_CYC (`CSMCC_LINK_PERIOD_NS / (2 * `CSMCC_CLK_PERIOD_NS))

// Transmit buffer depth in words.
`define CSMCC_FIFO_DEPTH 8

`endif

/* File: logic/csmcc_fifo.v */
`timescale 1ns/1ps
module csmcc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge pclk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // csmcc_fifo

/* File: logic/csmcc_shift.v */
`timescale 1ns/1ps
`include "csmcc_map.vh"
module csmcc_shift (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire abort,
  input wire [7:0] tx_byte,
  output reg busy_q,
  output reg done_q,
  output reg [7:0] rx_q,
  // Serial pins
  output reg sck_q,
  output reg mosi_q,
  input wire miso
);

  localparam integer HALF_I = `CSMCC_HALF_CYC - 1;
  localparam [2:0] HALF_M1 = HALF_I[2:0];

  reg miso_m_q;
  reg miso_s_q;
  reg [2:0] cnt_q;
  reg [2:0] bit_q;
  reg [7:0] tx_sh_q;
  reg [7:0] rx_sh_q;

  // Data is driven on the falling edge and sampled on the rising edge.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
      cnt_q <= 3'h0;
      bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      miso_m_q <= miso;
      miso_s_q <= miso_m_q;
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
        sck_q <= 1'b0;
      end
      else if (!busy_q)
      begin
        if (start)
        begin
          busy_q <= 1'b1;
          tx_sh_q <= tx_byte;
          mosi_q <= tx_byte[7];
          cnt_q <= 3'h0;
          bit_q <= 3'h0;
        end
      end
      else if (cnt_q != HALF_M1)
      begin
        cnt_q <= cnt_q + 3'h1;
      end
      else
      begin
        cnt_q <= 3'h0;
        sck_q <= ~sck_q;
        if (!sck_q)
        begin
          rx_sh_q <= {rx_sh_q[6:0], miso_s_q};
        end
        else if (bit_q == 3'h7)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          rx_q <= rx_sh_q;
        end
        else
        begin
          bit_q <= bit_q + 3'h1;
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          mosi_q <= tx_sh_q[6];
        end
      end
    end
  end

endmodule // csmcc_shift

/* File: logic/csmcc_top.v */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "csmcc_map.vh"
module csmcc_top (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial link
  output wire sck,
  output wire mosi,
  input wire miso,
  // Interrupt request
  output reg irq_q
);

  localparam [2:0] S_OFF = 3'b001;
  localparam [2:0] S_WAIT = 3'b010;
  localparam [2:0] S_RUN = 3'b100;
  localparam [15:0] RST_MODE = `CSMCC_RST_MODE;
  localparam [15:0] RST_COMM = `CSMCC_RST_COMM;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg irq_source_select_q;
  reg transmit_enable_bit_q;
  reg receive_enable_bit_q;
  reg [13:0] comm_low_q;
  reg [7:0] mask_q;
  reg [7:0] count_q;
  reg [7:0] remain_q;
  reg [7:0] remain_d;
  reg [7:0] rx_hold_q;
  reg buffer_full_flag_q;
  reg overrun_flag_q;
  reg [31:0] rdata_d;
  reg hit_d;

  wire setup;
  wire access;
  wire wr_en;
  wire rd_en;
  wire [15:0] mode_val;
  wire [15:0] comm_val;
  wire [7:0] status_val;
  wire channel_start_trigger;
  wire channel_stop_trigger;
  wire data_wr;
  wire data_rd;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire launch;
  wire need_tx;
  wire need_rx;
  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_rx;
  wire channel_enabled_status;
  wire transfer_active_flag;
  wire irq_event;

  // Bus phases: the answer is prepared in the setup cycle, so every access
  // completes at the first access-phase edge with no wait states.
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;
  assign rd_en = access & ~pwrite;

  assign channel_start_trigger = wr_en & (paddr == `CSMCC_OFS_START) &
    pwdata[`CSMCC_TRIG_CH];
  assign channel_stop_trigger = wr_en & (paddr == `CSMCC_OFS_STOP) &
    pwdata[`CSMCC_TRIG_CH];
  assign data_wr = wr_en & (paddr == `CSMCC_OFS_DATA) & fifo_in_ready;
  assign data_rd = rd_en & (paddr == `CSMCC_OFS_DATA);

  assign channel_enabled_status = ~state_q[0];
  assign transfer_active_flag = eng_busy;
  assign need_tx = transmit_enable_bit_q;
  assign need_rx = receive_enable_bit_q;

  // A character may only launch while the engine is idle and, when
  // transmitting, only once the buffer holds a word; otherwise it stalls.
  assign launch = state_q[2] & ~eng_busy & ~eng_done & ~channel_stop_trigger &
    (remain_q != 8'h00) & (~need_tx | fifo_out_valid);

  assign mode_val = {10'h000, 1'b1, 4'h0, irq_source_select_q};
  assign comm_val = {transmit_enable_bit_q, receive_enable_bit_q, comm_low_q};
  assign status_val = {1'b0, transfer_active_flag, buffer_full_flag_q, 4'h0,
    overrun_flag_q};

  always @*
  begin
    hit_d = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `CSMCC_OFS_STATUS: rdata_d = {24'h00_0000, status_val};
      `CSMCC_OFS_MODE: rdata_d = {16'h0000, mode_val};
      `CSMCC_OFS_COMM: rdata_d = {16'h0000, comm_val};
      `CSMCC_OFS_MASK: rdata_d = {24'h00_0000, mask_q};
      `CSMCC_OFS_START: rdata_d = 32'h0000_0000;
      `CSMCC_OFS_STOP: rdata_d = 32'h0000_0000;
      `CSMCC_OFS_DATA: rdata_d = {24'h00_0000, rx_hold_q};
      `CSMCC_OFS_COUNT: rdata_d = {24'h00_0000, count_q};
      `CSMCC_OFS_ENABLED: rdata_d = {31'h0000_0000, channel_enabled_status};
      default: hit_d = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      if (setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        // A data write into a full buffer is refused with an error.
        pslverr <= ~hit_d | (pwrite & (paddr == `CSMCC_OFS_DATA) & ~fifo_in_ready);
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_source_select_q <= RST_MODE[`CSMCC_MODE_IRQ_SRC];
      transmit_enable_bit_q <= RST_COMM[`CSMCC_COMM_TX_EN];
      receive_enable_bit_q <= RST_COMM[`CSMCC_COMM_RX_EN];
      comm_low_q <= RST_COMM[13:0];
      mask_q <= `CSMCC_RST_MASK;
      count_q <= `CSMCC_RST_COUNT;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CSMCC_OFS_MODE: irq_source_select_q <= pwdata[`CSMCC_MODE_IRQ_SRC];
        `CSMCC_OFS_COMM:
        begin
          transmit_enable_bit_q <= pwdata[`CSMCC_COMM_TX_EN];
          receive_enable_bit_q <= pwdata[`CSMCC_COMM_RX_EN];
          comm_low_q <= pwdata[13:0];
        end
        `CSMCC_OFS_MASK: mask_q <= pwdata[7:0];
        `CSMCC_OFS_COUNT: count_q <= pwdata[7:0];
        default: count_q <= count_q;
      endcase
    end
  end

  // Channel sequencing. Stop wins over a start in the same cycle.
  always @*
  begin
    state_d = state_q;
    remain_d = remain_q;
    case (state_q)
      S_OFF:
      begin
        if (channel_start_trigger)
        begin
          state_d = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (channel_stop_trigger)
        begin
          state_d = S_OFF;
        end
        else if (channel_start_trigger || (remain_q != 8'h00))
        begin
          // With both directions disabled the channel stays waiting.
          if (need_tx | need_rx)
          begin
            state_d = S_RUN;
          end
        end
      end
      S_RUN:
      begin
        if (channel_stop_trigger)
        begin
          state_d = S_OFF;
          remain_d = 8'h00;
        end
        else if (launch)
        begin
          remain_d = remain_q - 8'h01;
        end
        else if ((remain_q == 8'h00) && !eng_busy && !eng_done)
        begin
          state_d = S_WAIT;
        end
      end
      default: state_d = S_OFF;
    endcase
    // Each start reloads the block count; a count of zero moves nothing.
    if (channel_start_trigger && !channel_stop_trigger)
    begin
      remain_d = count_q;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_OFF;
      remain_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      remain_q <= remain_d;
    end
  end

  // Received characters land in a single holding word; a new one arriving
  // before software read the old one is flagged as an overrun. Set wins
  // over the read that would clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_hold_q <= 8'h00;
      buffer_full_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
    end
    else
    begin
      if (eng_done && need_rx)
      begin
        rx_hold_q <= eng_rx;
        buffer_full_flag_q <= 1'b1;
        if (buffer_full_flag_q && !data_rd)
        begin
          overrun_flag_q <= 1'b1;
        end
      end
      else if (data_rd)
      begin
        buffer_full_flag_q <= 1'b0;
        overrun_flag_q <= 1'b0;
      end
    end
  end

  // Event choice: a finished character, or the buffer handing its word to
  // the shifter. Nothing is raised while the channel is stopped.
  assign irq_event = (irq_source_select_q ? (launch & need_tx) : eng_done) &
    channel_enabled_status & ~channel_stop_trigger;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_event & ~mask_q[`CSMCC_MASK_SERIAL];
    end
  end

  csmcc_fifo #(
    .WIDTH(8),
    .DEPTH(`CSMCC_FIFO_DEPTH),
    .AW(3)
  ) u_txbuf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(launch & need_tx),
    .out_data(fifo_out_data)
  );

  // Receive-only transfers clock out all ones as filler.
  csmcc_shift u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .start(launch),
    .abort(channel_stop_trigger),
    .tx_byte(need_tx ? fifo_out_data : 8'hFF),
    .busy_q(eng_busy),
    .done_q(eng_done),
    .rx_q(eng_rx),
    .sck_q(sck),
    .mosi_q(mosi),
    .miso(miso)
  );

endmodule // csmcc_top

/* File: dv/csmcc_chk.sv */
`timescale 1ns/1ps
`include "csmcc_map.vh"
module csmcc_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Serial link and interrupt
  input wire sck,
  input wire mosi,
  input wire miso,
  input wire irq_q
);
  logic mask_q;
  logic mode_q;
  wire wr_done = psel && penable && pready && pwrite;
  wire rd_done = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow copies of the settings, so the interrupt checks know what software asked for.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_q <= 1'b1;
      mode_q <= 1'b0;
    end
    else
    begin
      if (wr_done && paddr == `CSMCC_OFS_MASK)
        mask_q <= pwdata[3];
      if (wr_done && paddr == `CSMCC_OFS_MODE)
        mode_q <= pwdata[0];
    end
  sequence s_high;
    sck [*4] ##1 !sck;
  endsequence
  sequence s_quiet;
    (!irq_q && !$rose(sck)) [*8];
  endsequence
  ready_no_wait_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  unmapped_err_a: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  active_flag_a: assert property (rd_done && paddr == 8'h00 && sck |-> prdata[6])
    else $error("active flag low while clock runs");
  mode_fixed_a: assert property (rd_done && paddr == `CSMCC_OFS_MODE |-> prdata[5])
    else $error("mode bit 5 not one");
  sck_high_a: assert property ($rose(sck) |-> s_high)
    else $error("serial clock high phase wrong");
  irq_pulse_a: assert property (irq_q |=> !irq_q)
    else $error("interrupt longer than one cycle");
  irq_mask_a: assert property (irq_q |-> !$past(mask_q))
    else $error("interrupt while masked");
  irq_tend_a: assert property (irq_q && !mode_q |-> $past(sck, 2) && !$past(sck))
    else $error("transfer end interrupt not after last fall");
  stop_quiet_a: assert property (wr_done && paddr == `CSMCC_OFS_STOP && pwdata[0] |=> s_quiet)
    else $error("activity after stop");
endmodule // csmcc_chk

/* File: dv/csmcc_slave.sv */
`timescale 1ns/1ps
module csmcc_slave (
  // Serial pins
  input wire sck,
  input wire mosi,
  output wire miso,
  // Answer byte and captured byte
  input wire [7:0] reply,
  output reg [7:0] got_q
);
  reg [2:0] nfall_q = 3'd0;
  initial got_q = 8'h00;
  // Most significant bit first; the next bit appears at each falling edge.
  assign miso = reply[3'd7 - nfall_q];
  always @(posedge sck)
    got_q <= {got_q[6:0], mosi};
  always @(negedge sck)
    nfall_q <= nfall_q + 3'd1;
endmodule // csmcc_slave

/* File: dv/csmcc_top_tb.sv */
`timescale 1ns/1ps
`include "csmcc_map.vh"
module csmcc_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0] reply = 8'h96;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire sck;
  wire mosi;
  wire miso;
  wire irq_q;
  wire [7:0] got;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rv;
  logic ev;

  always #50 pclk = ~pclk;

  csmcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .mosi(mosi), .miso(miso), .irq_q(irq_q));
  csmcc_slave u_slave (.sck(sck), .mosi(mosi), .miso(miso), .reply(reply), .got_q(got));

  task results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      chk("pready", 1, 0);
      results;
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rv & m);
  endtask

  // Stops early once n pulses are seen; with n of zero it watches the whole window.
  task irqs(input int n, input int win);
    int k;
    int c;
    c = 0;
    for (k = 0; k < win && !(n > 0 && c == n); k++)
    begin
      @(posedge pclk);
      if (irq_q === 1'b1)
        c++;
    end
    chk("irq count", n, c);
  endtask

  task setup(input logic [31:0] comm, input logic [31:0] mode);
    wr(`CSMCC_OFS_MASK, 32'h0000_00FF);
    wr(`CSMCC_OFS_STOP, 32'h0000_0001);
    wr(`CSMCC_OFS_COMM, comm);
    wr(`CSMCC_OFS_MODE, mode);
    wr(`CSMCC_OFS_MASK, 32'h0000_00F7);
  endtask

  task run(input logic [31:0] comm, input logic [31:0] mode, input logic [31:0] d);
    setup(comm, mode);
    wr(`CSMCC_OFS_COUNT, 32'h0000_0001);
    if (comm[15])
      wr(`CSMCC_OFS_DATA, d);
  endtask

  task t_reset;
    rdc("status", `CSMCC_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc("mode", `CSMCC_OFS_MODE, 32'hFFFF_FFFF, `CSMCC_RST_MODE);
    rdc("comm", `CSMCC_OFS_COMM, 32'hFFFF_FFFF, `CSMCC_RST_COMM);
    rdc("mask", `CSMCC_OFS_MASK, 32'hFFFF_FFFF, `CSMCC_RST_MASK);
    rdc("enabled", `CSMCC_OFS_ENABLED, 32'h0000_0001, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("slverr", 1, ev);
    wr(`CSMCC_OFS_MODE, 32'h0000_0000);
    rdc("mode", `CSMCC_OFS_MODE, 32'hFFFF_FFFF, 32'h0000_0020);
    wr(`CSMCC_OFS_MODE, 32'h0000_0001);
    rdc("mode", `CSMCC_OFS_MODE, 32'hFFFF_FFFF, 32'h0000_0021);
  endtask

  task t_tx;
    run(32'h0000_8007, 32'h0000_0000, 32'h0000_00A5);
    wr(`CSMCC_OFS_COUNT, 32'h0000_0002);
    wr(`CSMCC_OFS_DATA, 32'h0000_003C);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    wr(`CSMCC_OFS_STOP, 32'h0000_0000);
    rdc("enabled", `CSMCC_OFS_ENABLED, 32'h0000_0001, 32'h0000_0001);
    rdc("active", `CSMCC_OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
    irqs(2, 3000);
    chk("slave byte", 32'h0000_003C, {24'h00_0000, got});
    rdc("active", `CSMCC_OFS_STATUS, 32'h0000_0040, 32'h0000_0000);
  endtask

  task t_rx;
    run(32'h0000_4007, 32'h0000_0000, 32'h0000_0000);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    irqs(1, 300);
    rdc("rx word", `CSMCC_OFS_DATA, 32'h0000_00FF, 32'h0000_0096);
    chk("slave byte", 32'h0000_00FF, {24'h00_0000, got});
  endtask

  task t_both;
    reply <= 8'hC3;
    run(32'h0000_C007, 32'h0000_0001, 32'h0000_005A);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    irqs(1, 40);
    irqs(0, 100);
    rdc("rx word", `CSMCC_OFS_DATA, 32'h0000_00FF, 32'h0000_00C3);
    chk("slave byte", 32'h0000_005A, {24'h00_0000, got});
  endtask

  task t_quiet;
    run(32'h0000_4007, 32'h0000_0000, 32'h0000_0000);
    wr(`CSMCC_OFS_MASK, 32'h0000_00FF);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    irqs(0, 150);
    rdc("rx full", `CSMCC_OFS_STATUS, 32'h0000_0021, 32'h0000_0020);
    run(32'h0000_8007, 32'h0000_0000, 32'h0000_0077);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    wr(`CSMCC_OFS_STOP, 32'h0000_0001);
    rdc("enabled", `CSMCC_OFS_ENABLED, 32'h0000_0001, 32'h0000_0000);
    rdc("active", `CSMCC_OFS_STATUS, 32'h0000_0040, 32'h0000_0000);
    irqs(0, 150);
    run(32'h0000_0007, 32'h0000_0000, 32'h0000_0000);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    irqs(0, 150);
  endtask

  task t_fill;
    int i;
    setup(32'h0000_0007, 32'h0000_0000);
    for (i = 0; i < 9; i++)
    begin
      wr(`CSMCC_OFS_DATA, i);
      chk("full refusal", i == 8, ev);
    end
    wr(`CSMCC_OFS_COUNT, 32'h0000_0008);
    wr(`CSMCC_OFS_COMM, 32'h0000_8007);
    wr(`CSMCC_OFS_START, 32'h0000_0001);
    irqs(8, 1000);
    chk("slave byte", 32'h0000_0007, {24'h00_0000, got});
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_both;
    t_quiet;
    t_fill;
    results;
  end
endmodule // csmcc_top_tb

bind csmcc_top csmcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sck(sck), .mosi(mosi), .miso(miso), .irq_q(irq_q));
